// >>> design/rml_regs.sv
// Reference monitor limit registers with coarse and single cycle checks
`include "rml_params.svh"

// Software reaches the bank through a plain strobed port that never stalls.
// Phase hold codes are stored raw; the loop that consumes them applies the log scaling.
// Period measurements arrive from a sampler outside this block, already counted in ticks.
module rml_regs #(
    parameter int TICK_W = 24
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    // Read data stand only in the cycle after the read strobe
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    // Nominal periods of inputs 0 and 1, in 1.25 ns ticks
    input wire logic [TICK_W-1:0] ref0NomTicks,
    input wire logic [TICK_W-1:0] ref1NomTicks,
    // Period measurements of inputs 0 and 1
    // Valid bits are one-cycle pulses on this clock, so no synchroniser
    input wire rml_pkg::rml_meas_type ref0Meas,
    input wire rml_pkg::rml_meas_type ref1Meas,
    // Phase hold codes toward the loop
    // Raw codes; the consumer turns them into a time limit
    output logic [7:0] input0_phase_hold_code,
    output logic [7:0] input1_phase_hold_code,
    output logic [7:0] input2_phase_hold_code,
    output logic [7:0] input3_phase_hold_code,
    // Tolerance selects toward the monitors
    output rml_pkg::rml_tol_sel_type input0_coarse_tol_sel,
    output rml_pkg::rml_tol_sel_type input0_cycle_tol_sel,
    output rml_pkg::rml_tol_sel_type input1_coarse_tol_sel,
    output rml_pkg::rml_tol_sel_type input1_cycle_tol_sel,
    // Failure indicators and interrupt
    // Verdicts hold until the next sample of the same kind
    output logic ref0CoarseFail,
    output logic ref0CycleFail,
    output logic ref1CoarseFail,
    output logic ref1CycleFail,
    output logic irq
);

    // Phase hold code registers, one per input
    logic [7:0] ref0Phase_q; // Input 0 code as stored
    logic [7:0] ref0Phase_d; // Input 0 code after this cycle's write
    logic [7:0] ref1Phase_q; // Input 1 code as stored
    logic [7:0] ref1Phase_d; // Input 1 code after this cycle's write
    logic [7:0] ref2Phase_q; // Input 2 code as stored
    logic [7:0] ref2Phase_d; // Input 2 code after this cycle's write
    logic [7:0] ref3Phase_q; // Input 3 code as stored
    logic [7:0] ref3Phase_d; // Input 3 code after this cycle's write
    // Tolerance registers; full byte kept so reserved bits read back
    logic [7:0] ref0Tol_q; // Input 0 selects as stored
    logic [7:0] ref0Tol_d; // Input 0 selects after this cycle's write
    logic [7:0] ref1Tol_q; // Input 1 selects as stored
    logic [7:0] ref1Tol_d; // Input 1 selects after this cycle's write
    // Failure state, one bit per check in status bit order
    logic [3:0] live_q; // Latest verdict per check
    logic [3:0] live_d; // Verdict after this cycle's samples
    logic [3:0] status_q; // Sticky failure events
    logic [3:0] status_d; // Events after clear and set
    logic [3:0] mask_q; // Interrupt enables
    logic [3:0] mask_d; // Enables after this cycle's write
    logic irq_q; // Registered interrupt level
    logic irq_d; // Interrupt level from next-state values
    // Read path
    logic [7:0] rdData_q; // Answer of the previous cycle's read
    logic [7:0] rdData_d; // Answer being formed this cycle
    // Decoded tolerance fields
    rml_pkg::rml_tol_cfg_type cfg0; // Input 0 coarse and cycle selects
    rml_pkg::rml_tol_cfg_type cfg1; // Input 1 coarse and cycle selects
    // Comparator verdicts, meaningful only beside a matching sample
    logic over0Coarse; // Input 0 averaged period out of range
    logic over0Cycle; // Input 0 single period out of range
    logic over1Coarse; // Input 1 averaged period out of range
    logic over1Cycle; // Input 1 single period out of range
    // One-cycle failure events
    logic [3:0] failEvent; // Set pulses toward the sticky status

    // Only bits 2:0 and 6:4 steer the monitors; bits 3 and 7 are stored but unused
    always_comb begin
        cfg0.coarseSel = ref0Tol_q[`RML_COARSE_LSB +: 3]; // RULE4 RULE13
        cfg0.cycleSel = ref0Tol_q[`RML_CYCLE_LSB +: 3];   // RULE6 RULE13
        // Input 1 shares the field layout of input 0
        cfg1.coarseSel = ref1Tol_q[`RML_COARSE_LSB +: 3]; // RULE12
        cfg1.cycleSel = ref1Tol_q[`RML_CYCLE_LSB +: 3];   // RULE12
    end

    // Coarse check of input 0 on the averaged period
    // Averaging keeps cycle jitter from tripping the coarse check
    rml_tol_check #(
        .W(TICK_W)
    ) u_chk0Coarse (
        .nomTicks(ref0NomTicks),
        .measTicks(ref0Meas.avgTicks),
        .sel(cfg0.coarseSel),
        .over(over0Coarse)
    );

    // Single cycle check of input 0; tick granularity limits tight tolerances
    // A 1.25 ns tick cannot resolve 0.1 percent of a short period
    rml_tol_check #(
        .W(TICK_W)
    ) u_chk0Cycle (
        .nomTicks(ref0NomTicks),
        .measTicks(ref0Meas.cycTicks),
        .sel(cfg0.cycleSel),
        .over(over0Cycle)
    );

    // Coarse check of input 1
    // Same comparator, fed with the averaged period of input 1
    rml_tol_check #(
        .W(TICK_W)
    ) u_chk1Coarse (
        .nomTicks(ref1NomTicks),
        .measTicks(ref1Meas.avgTicks),
        .sel(cfg1.coarseSel),
        .over(over1Coarse)
    );

    // Single cycle check of input 1
    // Software masks this one where the frequency makes it unusable
    rml_tol_check #(
        .W(TICK_W)
    ) u_chk1Cycle (
        .nomTicks(ref1NomTicks),
        .measTicks(ref1Meas.cycTicks),
        .sel(cfg1.cycleSel),
        .over(over1Cycle)
    );

    // Configuration register writes
    always_comb begin
        ref0Phase_d = ref0Phase_q;
        ref1Phase_d = ref1Phase_q;
        ref2Phase_d = ref2Phase_q;
        ref3Phase_d = ref3Phase_q;
        ref0Tol_d = ref0Tol_q;
        ref1Tol_d = ref1Tol_q;
        mask_d = mask_q;
        // Only a write strobe changes configuration
        if (wrStb) begin
            unique case (addr)
                // Codes are stored raw; the loop applies the log scaling
                `RML_OFS_INPUT_REFERENCE_0_PHASE: ref0Phase_d = wrData; // RULE11 RULE1
                `RML_OFS_INPUT_REFERENCE_1_PHASE: ref1Phase_d = wrData; // RULE11 RULE1
                `RML_OFS_INPUT_REFERENCE_2_PHASE: ref2Phase_d = wrData; // RULE1
                `RML_OFS_INPUT_REFERENCE_3_PHASE: ref3Phase_d = wrData; // RULE1
                // Tolerance bytes kept whole, reserved bits included
                `RML_OFS_INPUT_REFERENCE_0_TOL: ref0Tol_d = wrData;     // RULE4 RULE6
                `RML_OFS_INPUT_REFERENCE_1_TOL: ref1Tol_d = wrData;     // RULE12
                // Mask holds bits 3:0 only
                `RML_OFS_FAIL_MASK: mask_d = wrData[3:0];
                default: begin
                    // Writes elsewhere are dropped
                end
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Defaults: phase codes 0x0a, selects 0x55, every interrupt masked
            ref0Phase_q <= `RML_RST_PHASE;
            ref1Phase_q <= `RML_RST_PHASE;
            ref2Phase_q <= `RML_RST_PHASE;
            ref3Phase_q <= `RML_RST_PHASE;
            ref0Tol_q <= `RML_RST_TOL;
            ref1Tol_q <= `RML_RST_TOL;
            mask_q <= 4'(`RML_RST_MASK);
        end else begin
            // Take this cycle's writes
            ref0Phase_q <= ref0Phase_d;
            ref1Phase_q <= ref1Phase_d;
            ref2Phase_q <= ref2Phase_d;
            ref3Phase_q <= ref3Phase_d;
            ref0Tol_q <= ref0Tol_d;
            ref1Tol_q <= ref1Tol_d;
            mask_q <= mask_d;
        end
    end

    // Verdicts update only on a fresh sample and hold until the next one
    always_comb begin
        live_d = live_q;
        failEvent = 4'h0;
        // A missing sample leaves the last verdict in place
        // Coarse check of input 0 on its averaged sample
        if (ref0Meas.avgValid) begin
            live_d[`RML_BIT_INPUT_REFERENCE_0_COARSE] = over0Coarse;             // RULE5
            failEvent[`RML_BIT_INPUT_REFERENCE_0_COARSE] = over0Coarse;          // RULE5
        end
        // Single cycle check of input 0, counted in 1.25 ns ticks
        if (ref0Meas.cycValid) begin
            live_d[`RML_BIT_INPUT_REFERENCE_0_CYCLE] = over0Cycle;               // RULE7 RULE8
            failEvent[`RML_BIT_INPUT_REFERENCE_0_CYCLE] = over0Cycle;            // RULE7
        end
        // Coarse check of input 1 on its averaged sample
        if (ref1Meas.avgValid) begin
            live_d[`RML_BIT_INPUT_REFERENCE_1_COARSE] = over1Coarse;             // RULE5
            failEvent[`RML_BIT_INPUT_REFERENCE_1_COARSE] = over1Coarse;          // RULE5
        end
        // Single cycle check of input 1, counted in 1.25 ns ticks
        if (ref1Meas.cycValid) begin
            live_d[`RML_BIT_INPUT_REFERENCE_1_CYCLE] = over1Cycle;               // RULE7 RULE8
            failEvent[`RML_BIT_INPUT_REFERENCE_1_CYCLE] = over1Cycle;            // RULE7
        end
    end

    // Sticky status: write one clears, a same-cycle event wins
    always_comb begin
        status_d = status_q;
        // Clear first, so that an event of the same cycle survives it
        if (wrStb && addr == `RML_OFS_FAIL_STATUS) begin
            status_d = status_q & ~wrData[3:0];
        end
        // Set from this cycle's failures
        status_d = status_d | failEvent;
        // Masking is how software silences unusable cycle checks
        irq_d = |(status_d & mask_d); // RULE10
    end

    // Live verdict register; a passing sample clears a bit again
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Every check reads as passing after reset
            live_q <= 4'h0;
        end else begin
            live_q <= live_d;
        end
    end

    // Sticky status and interrupt registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Nothing pending after reset
            status_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    // Read mux; unmapped addresses return zero
    always_comb begin
        rdData_d = 8'h00;
        // Only a read strobe forms an answer; otherwise the bus idles at zero
        if (rdStb) begin
            unique case (addr)
                // Configuration registers read back whole
                `RML_OFS_INPUT_REFERENCE_0_PHASE: rdData_d = ref0Phase_q;
                `RML_OFS_INPUT_REFERENCE_1_PHASE: rdData_d = ref1Phase_q;
                `RML_OFS_INPUT_REFERENCE_2_PHASE: rdData_d = ref2Phase_q;
                `RML_OFS_INPUT_REFERENCE_3_PHASE: rdData_d = ref3Phase_q;
                `RML_OFS_INPUT_REFERENCE_0_TOL: rdData_d = ref0Tol_q;
                `RML_OFS_INPUT_REFERENCE_1_TOL: rdData_d = ref1Tol_q;
                // Failure registers pad bits 7:4 with zero
                `RML_OFS_FAIL_STATUS: rdData_d = {4'h0, status_q}; // RULE5
                `RML_OFS_FAIL_MASK: rdData_d = {4'h0, mask_q};
                `RML_OFS_FAIL_LIVE: rdData_d = {4'h0, live_q};
                // Unmapped addresses answer zero
                default: rdData_d = 8'h00;
            endcase
        end
    end

    // Read data register; holds zero outside the answer cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Bus idles at zero
            rdData_q <= 8'h00;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // Outputs straight from flip-flops
    // Read answer
    assign rdData = rdData_q;
    // Phase hold codes
    assign input0_phase_hold_code = ref0Phase_q;
    assign input1_phase_hold_code = ref1Phase_q;
    assign input2_phase_hold_code = ref2Phase_q;
    assign input3_phase_hold_code = ref3Phase_q;
    // Tolerance selects; reserved bits 3 and 7 go nowhere
    assign input0_coarse_tol_sel = ref0Tol_q[`RML_COARSE_LSB +: 3];
    assign input0_cycle_tol_sel = ref0Tol_q[`RML_CYCLE_LSB +: 3];
    assign input1_coarse_tol_sel = ref1Tol_q[`RML_COARSE_LSB +: 3];
    assign input1_cycle_tol_sel = ref1Tol_q[`RML_CYCLE_LSB +: 3];
    // Failure levels
    assign ref0CoarseFail = live_q[`RML_BIT_INPUT_REFERENCE_0_COARSE];
    assign ref0CycleFail = live_q[`RML_BIT_INPUT_REFERENCE_0_CYCLE];
    assign ref1CoarseFail = live_q[`RML_BIT_INPUT_REFERENCE_1_COARSE];
    assign ref1CycleFail = live_q[`RML_BIT_INPUT_REFERENCE_1_CYCLE];
    // Interrupt level
    assign irq = irq_q;

endmodule

// >>> design/rml_params.svh
// Constants for the reference monitor limit register bank
// Contract
// RULE1: Phase hold code is 8-bit log-scaled limit
// RULE2: Software keeps limit above half reference period
// RULE3: Typical codes 0x00, 0x20, 0x40, 0x9f
// RULE4: Bits 2:0 select coarse frequency tolerance
// RULE5: Coarse violation raises coarse failure indicator
// RULE6: Bits 6:4 select single cycle tolerance
// RULE7: Single cycle violation raises cycle failure indicator
// RULE8: Periods measured in 1.25 ns ticks
// RULE9: Software picks cycle tolerance the frequency allows
// RULE10: Software masks cycle indicator above 400 MHz
// RULE11: Inputs 0 and 1 phase codes at 0x47, 0x48
// RULE12: Input 1 tolerance register at 0x4c
// RULE13: Reserved bits 3 and 7 are functionally ignored
`ifndef RML_PARAMS_SVH
`define RML_PARAMS_SVH

// Register offsets
`define RML_OFS_INPUT_REFERENCE_0_PHASE 8'h47
`define RML_OFS_INPUT_REFERENCE_1_PHASE 8'h48
`define RML_OFS_INPUT_REFERENCE_2_PHASE 8'h49
`define RML_OFS_INPUT_REFERENCE_3_PHASE 8'h4a
`define RML_OFS_INPUT_REFERENCE_0_TOL 8'h4b
`define RML_OFS_INPUT_REFERENCE_1_TOL 8'h4c
`define RML_OFS_FAIL_STATUS 8'h50
`define RML_OFS_FAIL_MASK 8'h51
`define RML_OFS_FAIL_LIVE 8'h52

// Reset values
`define RML_RST_PHASE 8'h0a
`define RML_RST_TOL 8'h55
`define RML_RST_MASK 8'h00

// Field positions of a tolerance register
`define RML_COARSE_LSB 0
`define RML_CYCLE_LSB 4

// Failure bit positions in status, mask and live registers
`define RML_BIT_INPUT_REFERENCE_0_COARSE 0
`define RML_BIT_INPUT_REFERENCE_0_CYCLE 1
`define RML_BIT_INPUT_REFERENCE_1_COARSE 2
`define RML_BIT_INPUT_REFERENCE_1_CYCLE 3

// Measurement tick of the 800 MHz sampling clock
`define RML_SAMPLE_MHZ 800
`define RML_TICK_PS (1000000 / `RML_SAMPLE_MHZ)

// Tolerances in units of 0.1 percent, per select code
`define RML_TOL_0 10'h001
`define RML_TOL_1 10'h005
`define RML_TOL_2 10'h00a
`define RML_TOL_3 10'h014
`define RML_TOL_4 10'h032
`define RML_TOL_5 10'h064
`define RML_TOL_6 10'h0c8
`define RML_TOL_7 10'h1f4
// Full scale of the tolerance unit: 1000 parts
`define RML_TOL_SCALE 10'h3e8

`endif

// >>> design/rml_pkg.sv
// Types shared by the reference monitor limit register bank
package rml_pkg;

    // Select code of a tolerance field
    typedef logic [2:0] rml_tol_sel_type;

    // Period measurement from the 800 MHz sampling engine, in ticks
    typedef struct packed {
        logic cycValid;         // One single-cycle period sample
        logic [23:0] cycTicks;  // Period of that single cycle
        logic avgValid;         // One averaged period sample
        logic [23:0] avgTicks;  // Averaged period for the coarse check
    } rml_meas_type;

    // Register bus request
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] addr;
        logic [7:0] wrData;
    } rml_bus_req_type;

    // Configuration of one monitored input
    typedef struct packed {
        rml_tol_sel_type coarseSel;
        rml_tol_sel_type cycleSel;
    } rml_tol_cfg_type;

endpackage

// >>> design/rml_tol_check.sv
// Combinational tolerance comparison of a measured period
`include "rml_params.svh"

module rml_tol_check #(
    parameter int W = 24
) (
    // Periods in sampling ticks
    input wire logic [W-1:0] nomTicks,
    input wire logic [W-1:0] measTicks,
    // Tolerance select code
    input wire rml_pkg::rml_tol_sel_type sel,
    // Violation result
    output logic over
);

    logic [9:0] tolParts;     // Allowed deviation in 0.1 percent parts
    logic [W-1:0] absDiff;    // Distance of measurement from nominal
    logic [W+9:0] lhs;        // Deviation scaled to full scale
    logic [W+9:0] rhs;        // Nominal scaled by tolerance

    // Decode the select code into a tolerance
    always_comb begin
        unique case (sel)
            3'h0: tolParts = `RML_TOL_0;
            3'h1: tolParts = `RML_TOL_1;
            3'h2: tolParts = `RML_TOL_2;
            3'h3: tolParts = `RML_TOL_3;
            3'h4: tolParts = `RML_TOL_4;
            3'h5: tolParts = `RML_TOL_5;
            3'h6: tolParts = `RML_TOL_6;
            3'h7: tolParts = `RML_TOL_7;
        endcase
    end

    // Cross-multiply so no divider is needed
    always_comb begin
        absDiff = (measTicks > nomTicks) ? measTicks - nomTicks : nomTicks - measTicks;
        lhs = (W+10)'(absDiff) * (W+10)'(`RML_TOL_SCALE);
        rhs = (W+10)'(nomTicks) * (W+10)'(tolParts);
        over = lhs > rhs;
    end

endmodule

// >>> tb/rml_regs_assertions.sv
// Checker of the reference monitor limit register bank
module rml_regs_checker #(
    parameter int TICK_W = 24
) (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    // Monitor inputs
    input wire logic [TICK_W-1:0] ref0NomTicks,
    input wire logic [TICK_W-1:0] ref1NomTicks,
    input wire rml_pkg::rml_meas_type ref0Meas,
    input wire rml_pkg::rml_meas_type ref1Meas,
    // Watched outputs
    input wire logic [7:0] input0_phase_hold_code,
    input wire logic [7:0] input2_phase_hold_code,
    input wire rml_pkg::rml_tol_sel_type input0_coarse_tol_sel,
    input wire rml_pkg::rml_tol_sel_type input0_cycle_tol_sel,
    input wire rml_pkg::rml_tol_sel_type input1_coarse_tol_sel,
    input wire rml_pkg::rml_tol_sel_type input1_cycle_tol_sel,
    input wire logic ref0CoarseFail,
    input wire logic ref1CycleFail
);
    timeunit 1ns;
    timeprecision 1ns;
    // Tolerance in tenths of a percent per select code
    localparam int TOLT[8] = '{1, 5, 10, 20, 50, 100, 200, 500};
    logic expC0_d; // Coarse verdict of this cycle's sample
    logic expC0_q;
    logic expS1_d; // Single cycle verdict of this cycle's sample
    logic expS1_q;

    // Strictly beyond the limit fails; exactly on it passes
    function automatic logic viol(input longint n, input longint m, input logic [2:0] s);
        longint d;
        d = (m > n) ? m - n : n - m;
        return d * 1000 > n * TOLT[s];
    endfunction

    // Verdicts from current selects, held one cycle as the outputs are registered
    always_comb begin
        expC0_d = viol(ref0NomTicks, ref0Meas.avgTicks, input0_coarse_tol_sel);
        expS1_d = viol(ref1NomTicks, ref1Meas.cycTicks, input1_cycle_tol_sel);
    end
    always_ff @(posedge clk) begin
        expC0_q <= expC0_d;
        expS1_q <= expS1_d;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_phase0_write: assert property (wrStb && addr == 8'h47 |=>
        input0_phase_hold_code == $past(wrData)) else $error("input 0 phase code not stored");
    chk_phase2_write: assert property (wrStb && addr == 8'h49 |=>
        input2_phase_hold_code == $past(wrData)) else $error("input 2 phase code not stored");
    chk_coarse_sel: assert property (wrStb && addr == 8'h4b |=>
        input0_coarse_tol_sel == $past(wrData[2:0])) else $error("input 0 coarse select wrong");
    chk_cycle_sel: assert property (wrStb && addr == 8'h4b |=>
        input0_cycle_tol_sel == $past(wrData[6:4])) else $error("input 0 cycle select wrong");
    chk_tol1_fields: assert property (wrStb && addr == 8'h4c |=>
        input1_coarse_tol_sel == $past(wrData[2:0]) && input1_cycle_tol_sel == $past(wrData[6:4]))
        else $error("input 1 selects wrong");
    chk_coarse_verdict: assert property (ref0Meas.avgValid |=>
        ref0CoarseFail == expC0_q) else $error("input 0 coarse verdict wrong");
    chk_cycle_verdict: assert property (ref1Meas.cycValid |=>
        ref1CycleFail == expS1_q) else $error("input 1 cycle verdict wrong");
    chk_verdict_hold: assert property (!ref0Meas.avgValid |=>
        $stable(ref0CoarseFail)) else $error("coarse verdict moved without a sample");
endmodule

bind rml_regs rml_regs_checker #(.TICK_W(TICK_W)) chk (
    .clk, .rst_n, .addr, .wrData, .wrStb, .ref0NomTicks, .ref1NomTicks, .ref0Meas, .ref1Meas,
    .input0_phase_hold_code, .input2_phase_hold_code, .input0_coarse_tol_sel,
    .input0_cycle_tol_sel, .input1_coarse_tol_sel, .input1_cycle_tol_sel,
    .ref0CoarseFail, .ref1CycleFail
);

// >>> tb/tb.sv
// Self-checking bench of the reference monitor limit register bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic [7:0] rdData;
    logic [23:0] nom = 24'h0003e8; // 1000 ticks of 1.25 ns on both inputs
    rml_pkg::rml_meas_type meas0 = '0;
    rml_pkg::rml_meas_type meas1 = '0;
    logic [7:0] ph0, ph1, ph2, ph3;
    rml_pkg::rml_tol_sel_type c0, s0, c1, s1;
    logic f0c, f0s, f1c, f1s, irq;
    int failures = 0;
    int checks = 0;
    int tol[8] = '{1, 5, 10, 20, 50, 100, 200, 500};
    logic [7:0] codes[4] = '{8'h00, 8'h20, 8'h40, 8'h9f};

    rml_regs #(.TICK_W(24)) uut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
        .rdData(rdData), .ref0NomTicks(nom), .ref1NomTicks(nom), .ref0Meas(meas0),
        .ref1Meas(meas1), .input0_phase_hold_code(ph0), .input1_phase_hold_code(ph1),
        .input2_phase_hold_code(ph2), .input3_phase_hold_code(ph3), .input0_coarse_tol_sel(c0),
        .input0_cycle_tol_sel(s0), .input1_coarse_tol_sel(c1), .input1_cycle_tol_sel(s1),
        .ref0CoarseFail(f0c), .ref0CycleFail(f0s), .ref1CoarseFail(f1c),
        .ref1CycleFail(f1s), .irq(irq)
    );

    // 100 ns period
    always #50 clk = ~clk;

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wrStb <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle there
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rdStb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdStb <= 1'b0;
        @(negedge clk);
        check(rdData, exp, "read data");
    endtask

    // One period sample, averaged or single cycle, then the verdict it should give
    task automatic sample(input bit r1, input bit cyc, input int ticks, input logic expFail);
        rml_pkg::rml_meas_type m;
        m = '0;
        m.cycValid = cyc;
        m.avgValid = !cyc;
        m.cycTicks = ticks[23:0];
        m.avgTicks = ticks[23:0];
        @(posedge clk);
        if (r1) meas1 <= m;
        else meas0 <= m;
        @(posedge clk);
        meas0 <= '0;
        meas1 <= '0;
        @(negedge clk);
        check({7'h00, r1 ? (cyc ? f1s : f1c) : (cyc ? f0s : f0c)}, {7'h00, expFail}, "verdict");
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        $display("mismatch at %0t: run timed out", $time);
        failures++;
        close_out();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, then an unmapped address
        for (int i = 0; i < 6; i++) begin
            rd(8'h47 + i[7:0], i < 4 ? 8'h0a : 8'h55);
        end
        @(negedge clk);
        check(rdData, 8'h00, "read data after answer");
        rd(8'h60, 8'h00);
        check({1'b0, s0, 1'b0, c0}, 8'h55, "input 0 reset selects");
        // Typical phase hold codes on input 2, codes derived from them on the others
        foreach (codes[i]) begin
            wr(8'h49, codes[i]);
            wr(8'h4a, ~codes[i]);
            wr(8'h47, codes[i] ^ 8'h5a);
            wr(8'h48, codes[i] ^ 8'ha5);
            rd(8'h49, codes[i]);
            check(ph2, codes[i], "input 2 code");
            check(ph3, ~codes[i], "input 3 code");
            check(ph0, codes[i] ^ 8'h5a, "input 0 code");
            check(ph1, codes[i] ^ 8'ha5, "input 1 code");
        end
        // Every select code with reserved bits set, checked exactly on the limit and one tick outside
        for (int s = 0; s < 8; s++) begin
            wr(8'h4b, {1'b1, s[2:0], 1'b1, s[2:0]});
            rd(8'h4b, {1'b1, s[2:0], 1'b1, s[2:0]});
            check({2'b00, c0, s0}, {2'b00, s[2:0], s[2:0]}, "input 0 selects");
            sample(0, 0, 1000 + tol[s], 1'b0);
            sample(0, 0, 999 - tol[s], 1'b1);
            sample(0, 1, 1000 - tol[s], 1'b0);
            sample(0, 1, 1001 + tol[s], 1'b1);
        end
        // Input 1: tightest cycle limit, widest coarse limit
        wr(8'h4c, 8'h07);
        @(negedge clk);
        check({2'b00, c1, s1}, 8'h38, "input 1 selects");
        sample(1, 1, 1002, 1'b1);
        sample(1, 0, 1500, 1'b0);
        sample(1, 0, 1501, 1'b1);
        sample(1, 1, 1001, 1'b0);
        // Sticky status, mask, clear and a fresh event
        rd(8'h50, 8'h0f);
        check({7'h00, irq}, 8'h00, "irq masked");
        wr(8'h51, 8'h02);
        @(negedge clk);
        check({7'h00, irq}, 8'h01, "irq raised");
        wr(8'h50, 8'h02);
        @(negedge clk);
        check({7'h00, irq}, 8'h00, "irq cleared");
        rd(8'h50, 8'h0d);
        rd(8'h51, 8'h02);
        sample(0, 1, 2000, 1'b1);
        check({7'h00, irq}, 8'h01, "irq on new event");
        rd(8'h52, 8'h07);
        wr(8'h51, 8'h00);
        @(negedge clk);
        check({7'h00, irq}, 8'h00, "irq unmasked off");
        close_out();
    end
endmodule
